/* File: shared/loop_tally_pkg.sv */
// Constants and types for the loopback and error tally block
package loop_tally_pkg;
  // Register offsets
  localparam logic [3:0] ADDR_TX_CONFIG    = 4'h0;
  localparam logic [3:0] ADDR_TX_COUNT_LO  = 4'h1;
  localparam logic [3:0] ADDR_TX_COUNT_HI  = 4'h2;
  localparam logic [3:0] ADDR_CMD          = 4'h3;
  localparam logic [3:0] ADDR_TX_STATUS    = 4'h4;
  localparam logic [3:0] ADDR_RX_STATUS    = 4'h5;
  localparam logic [3:0] ADDR_INT_STATUS   = 4'h6;
  localparam logic [3:0] ADDR_CRC_TALLY    = 4'h7;
  localparam logic [3:0] ADDR_ALIGN_TALLY  = 4'h8;
  localparam logic [3:0] ADDR_MISS_TALLY   = 4'h9;
  localparam logic [3:0] ADDR_FIFO_PORT    = 4'hA;
  localparam logic [3:0] ADDR_RX_COUNT     = 4'hB;
  localparam logic [3:0] ADDR_THRESHOLD    = 4'hC;
  // Transmit config fields
  localparam int         CFG_CRC_INHIBIT   = 0;
  localparam int         CFG_LOOP_LO       = 1;
  localparam int         CFG_LOOP_HI       = 2;
  // Loop select codes
  localparam logic [1:0] LOOP_NONE         = 2'h0;
  localparam logic [1:0] LOOP_INTERNAL     = 2'h1;
  localparam logic [1:0] LOOP_ENCODER      = 2'h2;
  localparam logic [1:0] LOOP_CABLE        = 2'h3;
  // Status bit positions
  localparam int         TXS_DONE          = 0;
  localparam int         TXS_COLLIDED      = 1;
  localparam int         TXS_DEFERRED      = 2;
  localparam int         TXS_CARRIER_LOST  = 4;
  localparam int         TXS_HEARTBEAT     = 6;
  localparam int         RXS_INTACT        = 0;
  localparam int         RXS_CRC_ERR       = 1;
  localparam int         RXS_ALIGN_ERR     = 2;
  localparam int         RXS_MULTICAST     = 5;
  localparam int         INT_PKT_RX        = 0;
  localparam int         INT_PKT_TX        = 1;
  localparam int         INT_TX_ERR        = 3;
  // Framing figures
  localparam int         PREAMBLE_BITS     = 56;
  localparam int         SYNC_BITS         = 8;
  localparam int         PREAMBLE_BYTES    = (PREAMBLE_BITS + SYNC_BITS) / 8;
  localparam int         CRC_BYTES         = 4;
  localparam logic [7:0] PREAMBLE_BYTE     = 8'h55;
  localparam logic [7:0] SYNC_BYTE         = 8'hD5;
  localparam logic [7:0] TALLY_LIMIT       = 8'hC0;
  localparam logic [7:0] THRESHOLD_RST     = 8'h04;
  localparam logic [31:0] CRC_POLY         = 32'hEDB8_8320;
  localparam logic [31:0] CRC_RESIDUE      = 32'hDEBB_20E3;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_PRE   = 3'b001,
    TX_DATA  = 3'b011,
    TX_CRC   = 3'b010,
    TX_DONE  = 3'b110
  } tx_state_t;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte
endpackage : loop_tally_pkg

/* File: src/loop_tally.sv */
// Loopback self-test path and network error tally counters
//
// Functional notes
// - Loopback splits FIFO into transmit/receive halves
// - DMA fills transmit half, decrements count
// - Send 56-bit preamble then sync byte
// - CRC inhibit omits CRC, else append four
// - Transmit completion sets packet transmitted flag, except after a cable-loop collision
// - Receiver strips preamble, stores, counts bytes
// - Check CRC only when inhibit bit set
// - End: write count into FIFO, update status
// - CRC/alignment errors only on address match
// - Packet received flag stays zero in loopback
// - Internal loop: carrier and heartbeat lost
// - Encoder loop: heartbeat lost only
// - Cable loop: neither; untransmittable flags error
// - Cable loop obeys deferral and collision
// - Multicast match sets multicast status bit
// - Mismatch with bad CRC reads intact
// - Separate 8-bit CRC and alignment counters
// - Counter MSB raises interrupt request
// - Counters stop at 192
// - Third counter tallies missed packets
// - Transmit status updated after each send
// - FIFO port reads advance read pointer
`timescale 1ns/1ns
module loop_tally
  import loop_tally_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic       CORE_CLK_IN,      // 100 MHz clock
  input  wire logic       NRST_IN,          // Async reset, active low
  input  wire logic [3:0] ADDR_IN,          // Register address
  input  wire logic [7:0] WDATA_IN,         // Write data
  input  wire logic       WR_IN,            // Write strobe
  input  wire logic       RD_IN,            // Read strobe
  output logic      [7:0] RDATA_OUT,        // Read data, cycle after strobe
  input  wire logic       MEM_VALID_IN,     // Memory byte available
  input  wire logic [7:0] MEM_DATA_IN,      // Memory byte
  output logic            MEM_REQ_OUT,      // DMA fetch request
  input  wire logic       CARRIER_IN,       // Medium busy (cable loop)
  input  wire logic       COLLISION_IN,     // Collision seen (cable loop)
  input  wire logic       HEARTBEAT_IN,     // Heartbeat seen after send
  input  wire logic       ADDR_MATCH_IN,    // Physical address filter hit
  input  wire logic       MCAST_MATCH_IN,   // Multicast filter hit
  input  wire logic       ALIGN_ERR_IN,     // Frame alignment error seen
  input  wire logic       MISSED_IN,        // Packet missed pulse
  output logic            TALLY_IRQ_OUT     // Tally counter MSB set
);
  localparam int HALF = FIFO_DEPTH / 2;
  localparam int PW   = $clog2(HALF);

  // Fill compare pads to eight bits, so depth is capped at 256
  if (FIFO_DEPTH < 4 || FIFO_DEPTH > 256 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_chk
    $error("FIFO_DEPTH must be a power of two from 4 to 256");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  tx_config_ff;
  logic [15:0] tx_count_ff;
  logic [7:0]  threshold_ff;
  logic [7:0]  tx_status_ff;
  logic [7:0]  rx_status_ff;
  logic [7:0]  int_status_ff;
  logic [7:0]  crc_tally_ff;
  logic [7:0]  align_tally_ff;
  logic [7:0]  miss_tally_ff;
  logic [15:0] rx_count_ff;
  logic [1:0]  loop_sel;
  logic        crc_inhibit;
  logic        start_cmd;
  logic        rd_fifo;

  assign loop_sel    = {tx_config_ff[CFG_LOOP_HI], tx_config_ff[CFG_LOOP_LO]};
  assign crc_inhibit = tx_config_ff[CFG_CRC_INHIBIT];
  assign start_cmd   = WR_IN && ADDR_IN == ADDR_CMD && WDATA_IN[0];
  assign rd_fifo     = RD_IN && ADDR_IN == ADDR_FIFO_PORT;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit half of the FIFO
  logic [7:0]    tx_mem [HALF];
  logic [PW-1:0] tx_wp_ff;
  logic [PW-1:0] tx_rp_ff;
  logic [PW:0]   tx_fill_ff;
  logic          fetching_ff;
  logic          tx_push;
  logic          tx_pop;
  tx_state_t     tx_st_ff;
  logic [2:0]    bytecnt_ff;
  logic [31:0]   tx_crc_ff;

  assign tx_push = fetching_ff && MEM_VALID_IN && tx_fill_ff != (PW + 1)'(HALF)
                   && tx_count_ff != 16'h0000;
  assign tx_pop  = tx_st_ff == TX_DATA && tx_fill_ff != '0;

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      fetching_ff <= 1'b0;
    end else if (tx_count_ff == 16'h0000 || (tx_push && tx_count_ff == 16'h0001)) begin
      fetching_ff <= 1'b0;
    end else if (tx_fill_ff == (PW + 1)'(HALF) || (tx_push && tx_fill_ff == (PW + 1)'(HALF - 1))) begin
      fetching_ff <= 1'b0;
    end else if (tx_st_ff != TX_IDLE && {{(7 - PW){1'b0}}, tx_fill_ff} < threshold_ff) begin
      fetching_ff <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (tx_push) begin
      tx_mem[tx_wp_ff] <= MEM_DATA_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_wp_ff   <= '0;
      tx_rp_ff   <= '0;
      tx_fill_ff <= '0;
    end else begin
      tx_wp_ff   <= tx_wp_ff + PW'(tx_push);
      tx_rp_ff   <= tx_rp_ff + PW'(tx_pop);
      tx_fill_ff <= tx_fill_ff + (PW + 1)'(tx_push) - (PW + 1)'(tx_pop);
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_count_ff <= 16'h0000;
    end else if (WR_IN && ADDR_IN == ADDR_TX_COUNT_LO) begin
      tx_count_ff[7:0] <= WDATA_IN;
    end else if (WR_IN && ADDR_IN == ADDR_TX_COUNT_HI) begin
      tx_count_ff[15:8] <= WDATA_IN;
    end else if (tx_push) begin
      tx_count_ff <= tx_count_ff - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serializer side (byte-wide)
  logic [7:0] ser_byte;
  logic       ser_valid;
  logic       ser_sync;
  logic       tx_last;
  logic       cable_busy;

  assign cable_busy = loop_sel == LOOP_CABLE && CARRIER_IN;
  assign tx_last    = tx_count_ff == 16'h0000 && tx_fill_ff == (PW + 1)'(1) && tx_pop;

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_st_ff   <= TX_IDLE;
      bytecnt_ff <= '0;
    end else begin
      case (tx_st_ff)
        TX_IDLE: begin
          if (start_cmd && loop_sel != LOOP_NONE) begin
            tx_st_ff   <= TX_PRE;
            bytecnt_ff <= '0;
          end
        end
        TX_PRE: begin
          if (!cable_busy && tx_fill_ff != '0) begin
            bytecnt_ff <= bytecnt_ff + 3'd1;
            if (bytecnt_ff == 3'(PREAMBLE_BYTES - 1)) begin
              tx_st_ff <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          if (tx_last) begin
            tx_st_ff   <= crc_inhibit ? TX_DONE : TX_CRC;
            bytecnt_ff <= '0;
          end
        end
        TX_CRC: begin
          bytecnt_ff <= bytecnt_ff + 3'd1;
          if (bytecnt_ff == 3'(CRC_BYTES - 1)) begin
            tx_st_ff <= TX_DONE;
          end
        end
        TX_DONE: tx_st_ff <= TX_IDLE;
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  always_comb begin
    ser_valid = 1'b0;
    ser_sync  = 1'b0;
    ser_byte  = 8'h00;
    case (tx_st_ff)
      TX_PRE: begin
        ser_valid = !cable_busy && tx_fill_ff != '0;
        ser_sync  = bytecnt_ff == 3'(PREAMBLE_BYTES - 1);
        ser_byte  = ser_sync ? SYNC_BYTE : PREAMBLE_BYTE;
      end
      TX_DATA: begin
        ser_valid = tx_pop;
        ser_byte  = tx_mem[tx_rp_ff];
      end
      TX_CRC: begin
        ser_valid = 1'b1;
        ser_byte  = ~tx_crc_ff[8 * bytecnt_ff[1:0] +: 8];
      end
      default: ser_valid = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_crc_ff <= 32'hFFFF_FFFF;
    end else if (tx_st_ff == TX_PRE) begin
      tx_crc_ff <= 32'hFFFF_FFFF;
    end else if (tx_pop && !crc_inhibit) begin
      tx_crc_ff <= crc_byte(tx_crc_ff, tx_mem[tx_rp_ff]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive half: deserializer fed straight from serializer
  logic [7:0]    rx_mem [HALF];
  logic [PW-1:0] rx_wp_ff;
  logic [PW-1:0] rx_rp_ff;
  logic          rx_active_ff;
  logic [31:0]   rx_crc_ff;
  logic [1:0]    tail_ff;
  logic          rx_store;
  logic [7:0]    tail_byte;
  logic          tx_end;

  assign tx_end   = tx_st_ff == TX_DONE;
  assign rx_store = rx_active_ff && ser_valid;
  always_comb begin
    case (tail_ff)
      2'd1:    tail_byte = rx_count_ff[7:0];
      default: tail_byte = rx_count_ff[15:8];
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rx_active_ff <= 1'b0;
    end else if (tx_end) begin
      rx_active_ff <= 1'b0;
    end else if (ser_valid && ser_sync) begin
      rx_active_ff <= 1'b1;
    end
  end

  // receive half; count written into FIFO
  always_ff @(posedge CORE_CLK_IN) begin
    if (rx_store) begin
      rx_mem[rx_wp_ff] <= ser_byte;
    end else if (tail_ff != 2'd0) begin
      rx_mem[rx_wp_ff] <= tail_byte;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rx_wp_ff    <= '0;
      rx_count_ff <= 16'h0000;
      rx_crc_ff   <= 32'hFFFF_FFFF;
      tail_ff     <= 2'd0;
    end else if (start_cmd) begin
      rx_wp_ff    <= '0;
      rx_count_ff <= 16'h0000;
      rx_crc_ff   <= 32'hFFFF_FFFF;
    end else if (rx_store) begin
      rx_wp_ff    <= rx_wp_ff + PW'(1);
      rx_count_ff <= rx_count_ff + 16'h0001;
      rx_crc_ff   <= crc_byte(rx_crc_ff, ser_byte);
    end else if (tx_end) begin
      tail_ff <= 2'd1;
    end else if (tail_ff != 2'd0) begin
      rx_wp_ff <= rx_wp_ff + PW'(1);
      tail_ff  <= tail_ff == 2'd3 ? 2'd0 : tail_ff + 2'd1;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rx_rp_ff <= '0;
    end else if (tx_end) begin
      rx_rp_ff <= rx_wp_ff + PW'(4);
    end else if (rd_fifo) begin
      rx_rp_ff <= rx_rp_ff + PW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status
  logic addr_hit;
  logic crc_bad;
  logic rx_fin;
  logic rx_fin_ff;
  logic coll_seen_ff;
  logic hb_seen_ff;
  logic defer_seen_ff;

  assign addr_hit = ADDR_MATCH_IN || MCAST_MATCH_IN;
  // check only when inhibit set, else always flagged
  assign crc_bad  = crc_inhibit ? (rx_crc_ff != CRC_RESIDUE) : 1'b1;
  assign rx_fin   = tail_ff == 2'd3;

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      coll_seen_ff  <= 1'b0;
      hb_seen_ff    <= 1'b0;
      defer_seen_ff <= 1'b0;
    end else if (start_cmd) begin
      coll_seen_ff  <= 1'b0;
      hb_seen_ff    <= 1'b0;
      defer_seen_ff <= 1'b0;
    end else if (loop_sel == LOOP_CABLE) begin
      coll_seen_ff  <= coll_seen_ff | (COLLISION_IN && tx_st_ff != TX_IDLE);
      hb_seen_ff    <= hb_seen_ff | HEARTBEAT_IN;
      defer_seen_ff <= defer_seen_ff | cable_busy;
    end else if (loop_sel == LOOP_ENCODER) begin
      hb_seen_ff    <= 1'b0;
    end
  end

  // transmit status per send; carrier and heartbeat
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_status_ff <= 8'h00;
    end else if (tx_end) begin
      tx_status_ff                   <= 8'h00;
      tx_status_ff[TXS_DONE]         <= 1'b1;
      // Cable loop: set unless a collision was seen
      tx_status_ff[TXS_COLLIDED]     <= loop_sel != LOOP_CABLE || !coll_seen_ff;
      tx_status_ff[TXS_DEFERRED]     <= defer_seen_ff;
      tx_status_ff[TXS_CARRIER_LOST] <= loop_sel == LOOP_INTERNAL;
      tx_status_ff[TXS_HEARTBEAT]    <= loop_sel != LOOP_CABLE || !hb_seen_ff
                                        && loop_sel != LOOP_CABLE;
    end
  end

  // status update; errors only on match; status codes
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rx_status_ff <= 8'h00;
      rx_fin_ff    <= 1'b0;
    end else begin
      rx_fin_ff <= rx_fin;
      if (rx_fin) begin
        rx_status_ff                <= 8'h00;
        rx_status_ff[RXS_CRC_ERR]   <= addr_hit && crc_bad;
        rx_status_ff[RXS_ALIGN_ERR] <= addr_hit && ALIGN_ERR_IN;
        rx_status_ff[RXS_INTACT]    <= !(addr_hit && (crc_bad || ALIGN_ERR_IN));
        rx_status_ff[RXS_MULTICAST] <= MCAST_MATCH_IN;
      end
    end
  end

  // transmitted flag; received flag held zero; error flag
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      int_status_ff <= 8'h00;
    end else begin
      if (WR_IN && ADDR_IN == ADDR_INT_STATUS) begin
        int_status_ff <= int_status_ff & ~WDATA_IN;
      end
      if (tx_end) begin
        int_status_ff[INT_PKT_TX] <= !(coll_seen_ff && loop_sel == LOOP_CABLE);
        int_status_ff[INT_TX_ERR] <= coll_seen_ff && loop_sel == LOOP_CABLE;
      end
      int_status_ff[INT_PKT_RX] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tally counters
  logic crc_ev;
  logic align_ev;

  assign crc_ev   = rx_fin && addr_hit && crc_bad;
  assign align_ev = rx_fin && addr_hit && ALIGN_ERR_IN;

  // separate counters; stop at limit; read clears
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      crc_tally_ff <= 8'h00;
    end else if (RD_IN && ADDR_IN == ADDR_CRC_TALLY) begin
      crc_tally_ff <= 8'(crc_ev);
    end else if (crc_ev && crc_tally_ff < TALLY_LIMIT) begin
      crc_tally_ff <= crc_tally_ff + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      align_tally_ff <= 8'h00;
    end else if (RD_IN && ADDR_IN == ADDR_ALIGN_TALLY) begin
      align_tally_ff <= 8'(align_ev);
    end else if (align_ev && align_tally_ff < TALLY_LIMIT) begin
      align_tally_ff <= align_tally_ff + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      miss_tally_ff <= 8'h00;
    end else if (RD_IN && ADDR_IN == ADDR_MISS_TALLY) begin
      miss_tally_ff <= 8'(MISSED_IN);
    end else if (MISSED_IN && miss_tally_ff < TALLY_LIMIT) begin
      miss_tally_ff <= miss_tally_ff + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      TALLY_IRQ_OUT <= 1'b0;
    end else begin
      TALLY_IRQ_OUT <= crc_tally_ff[7] | align_tally_ff[7] | miss_tally_ff[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  // loop select written by software
  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      tx_config_ff <= 8'h00;
      threshold_ff <= THRESHOLD_RST;
    end else if (WR_IN && ADDR_IN == ADDR_TX_CONFIG) begin
      tx_config_ff <= WDATA_IN;
    end else if (WR_IN && ADDR_IN == ADDR_THRESHOLD) begin
      threshold_ff <= WDATA_IN;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      MEM_REQ_OUT <= 1'b0;
    end else begin
      MEM_REQ_OUT <= fetching_ff && !tx_push;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (RD_IN) begin
      case (ADDR_IN)
        ADDR_TX_CONFIG:   RDATA_OUT <= tx_config_ff;
        ADDR_TX_COUNT_LO: RDATA_OUT <= tx_count_ff[7:0];
        ADDR_TX_COUNT_HI: RDATA_OUT <= tx_count_ff[15:8];
        ADDR_TX_STATUS:   RDATA_OUT <= tx_status_ff;
        ADDR_RX_STATUS:   RDATA_OUT <= rx_status_ff;
        ADDR_INT_STATUS:  RDATA_OUT <= int_status_ff;
        ADDR_CRC_TALLY:   RDATA_OUT <= crc_tally_ff;
        ADDR_ALIGN_TALLY: RDATA_OUT <= align_tally_ff;
        ADDR_MISS_TALLY:  RDATA_OUT <= miss_tally_ff;
        ADDR_FIFO_PORT:   RDATA_OUT <= rx_mem[rx_rp_ff];
        ADDR_RX_COUNT:    RDATA_OUT <= rx_count_ff[7:0];
        ADDR_THRESHOLD:   RDATA_OUT <= threshold_ff;
        default:          RDATA_OUT <= 8'h00;
      endcase
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  saturate_stop_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    crc_tally_ff <= TALLY_LIMIT && align_tally_ff <= TALLY_LIMIT
    && miss_tally_ff <= TALLY_LIMIT) else $error("tally passed limit");
  rx_flag_zero_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    !int_status_ff[INT_PKT_RX]) else $error("received flag set");
  tx_flag_set_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    tx_end && loop_sel != LOOP_CABLE |=> int_status_ff[INT_PKT_TX])
    else $error("transmitted flag missing");
  mismatch_clean_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    rx_fin && !addr_hit |=> !rx_status_ff[RXS_CRC_ERR] && !rx_status_ff[RXS_ALIGN_ERR])
    else $error("error on mismatch");
  tally_irq_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    crc_tally_ff[7] || align_tally_ff[7] || miss_tally_ff[7] |=> TALLY_IRQ_OUT)
    else $error("tally irq missing");
  read_clear_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    RD_IN && ADDR_IN == ADDR_MISS_TALLY && !MISSED_IN |=> miss_tally_ff == 8'h00)
    else $error("tally not cleared");
  fill_bound_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    tx_fill_ff <= (PW + 1)'(HALF)) else $error("transmit half overfilled");
  count_down_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
    tx_push |=> tx_count_ff == $past(tx_count_ff) - 16'h0001)
    else $error("count not decremented");
endmodule : loop_tally

/* File: tb/mem_model.sv */
// Byte-wide system memory answering the loopback DMA fetches
`timescale 1ns/1ns
module mem_model (
  input  wire logic       clk,      // Core clock
  input  wire logic       nrst,     // Async reset, active low
  input  wire logic       restart,  // Rewind to first byte
  input  wire logic       slow,     // Insert a gap after each byte
  input  wire logic       req,      // Fetch request
  output logic            valid,    // Byte available
  output logic      [7:0] data      // Byte
);
  logic [7:0] mem [0:31];
  logic [4:0] idx;
  logic       ph;
  logic       give;

  // One byte per request; the DMA takes it while valid stands
  assign give = req && !valid && (!slow || ph);

  ////////////////////////////////////////////////////////////
  // bytes served in order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx   <= 5'h00;
      ph    <= 1'b0;
      valid <= 1'b0;
      data  <= 8'hFF;
    end else if (restart) begin
      idx   <= 5'h00;
      ph    <= 1'b0;
      valid <= 1'b0;
      data  <= 8'hFF;
    end else begin
      ph    <= ~ph;
      idx   <= idx + 5'(give);
      valid <= give;
      data  <= give ? mem[idx] : ~data;
    end
  end
endmodule : mem_model

/* File: tb/tb_loop_tally.sv */
// Self-checking bench for the loopback path and tally counters
`timescale 1ns/1ns
module tb_loop_tally;
  import loop_tally_pkg::*;
  logic       clk, nrst, wr, rd, mv, req, irq, am, mm, miss, rst_m, slow;
  logic       car, col, ae;
  logic [3:0] addr;
  logic [7:0] wd, rdata, md;
  int         fails, compares;

  loop_tally DUT (.CORE_CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wd),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .MEM_VALID_IN(mv), .MEM_DATA_IN(md),
    .MEM_REQ_OUT(req), .CARRIER_IN(car), .COLLISION_IN(col), .HEARTBEAT_IN(1'b0),
    .ADDR_MATCH_IN(am), .MCAST_MATCH_IN(mm), .ALIGN_ERR_IN(ae), .MISSED_IN(miss),
    .TALLY_IRQ_OUT(irq));
  mem_model mem_u (.clk(clk), .nrst(nrst), .restart(rst_m), .slow(slow), .req(req),
    .valid(mv), .data(md));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  task end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task rd_reg(input logic [3:0] a, input logic [7:0] e, input string n);
    addr <= a; rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(n, e, rdata);
    @(posedge clk);
  endtask : rd_reg

  // Software FCS over the first n bytes, sent low byte first
  function automatic logic [31:0] fcs(input int n);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < n; i++)
      for (int b = 0; b < 8; b++)
        c = (c[0] ^ mem_u.mem[i][b]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    return ~c;
  endfunction : fcs

  // One loopback packet; sw: 0 none, 1 good FCS, 2 bad FCS
  task run(input logic [7:0] cfg, input int sw, input logic [7:0] transmit_status_register, input logic [7:0] receive_status_register,
    input logic [7:0] interrupt_status_register);
    logic [31:0] f;
    int          n;
    n = sw ? 16 : 12;
    for (int i = 0; i < 12; i++) mem_u.mem[i] = 8'(8'h30 + i);
    f = fcs(12);
    for (int i = 0; i < 4; i++) mem_u.mem[12 + i] = f[8*i +: 8] ^ {7'h0, sw == 2};
    wr_reg(ADDR_TX_CONFIG, 8'h00);
    wr_reg(ADDR_INT_STATUS, 8'hFF);
    rst_m <= 1'b1;
    wr_reg(ADDR_TX_CONFIG, cfg);
    rst_m <= 1'b0;
    wr_reg(ADDR_TX_COUNT_LO, 8'(n));
    wr_reg(ADDR_TX_COUNT_HI, 8'h00);
    wr_reg(ADDR_CMD, 8'h01);
    for (int k = 0; k < 4000; k++) begin
      addr <= ADDR_INT_STATUS; rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      @(negedge clk);
      if (rdata[INT_PKT_TX] === 1'b1 || rdata[INT_TX_ERR] === 1'b1) break;
      @(posedge clk);
    end
    @(posedge clk);
    repeat (20) @(posedge clk);
    rd_reg(ADDR_TX_STATUS, transmit_status_register, "tx status");
    rd_reg(ADDR_RX_STATUS, receive_status_register, "rx status");
    rd_reg(ADDR_INT_STATUS, interrupt_status_register, "int status");
    rd_reg(ADDR_RX_COUNT, 8'(cfg[0] ? n : n + 4), "rx count");
  endtask : run

  task crc_tests;
    am <= 1'b1;
    run(8'h02, 0, 8'h53, 8'h02, 8'h02);
    slow <= 1'b1;
    run(8'h04, 0, 8'h43, 8'h02, 8'h02);
    slow <= 1'b0;
    run(8'h03, 1, 8'h53, 8'h01, 8'h02);
    run(8'h03, 2, 8'h53, 8'h02, 8'h02);
    am <= 1'b0; mm <= 1'b1;
    run(8'h03, 1, 8'h53, 8'h21, 8'h02);
    run(8'h03, 2, 8'h53, 8'h22, 8'h02);
    mm <= 1'b0;
    run(8'h03, 2, 8'h53, 8'h01, 8'h02);
    rd_reg(ADDR_CRC_TALLY, 8'h04, "crc tally");
    rd_reg(ADDR_CRC_TALLY, 8'h00, "crc tally cleared");
  endtask : crc_tests

  task align_tests;
    am <= 1'b1; ae <= 1'b1;
    run(8'h03, 1, 8'h53, 8'h04, 8'h02);
    ae <= 1'b0;
    rd_reg(ADDR_ALIGN_TALLY, 8'h01, "align tally");
    rd_reg(ADDR_ALIGN_TALLY, 8'h00, "align tally cleared");
  endtask : align_tests

  // Carrier held at start forces deferral; collision makes it untransmittable
  task cable_tests;
    car <= 1'b1;
    fork
      run(8'h06, 0, 8'h07, 8'h02, 8'h02);
      begin
        repeat (60) @(posedge clk);
        car <= 1'b0;
      end
    join
    col <= 1'b1;
    run(8'h06, 0, 8'h01, 8'h02, 8'h08);
    col <= 1'b0; am <= 1'b0;
    rd_reg(ADDR_CRC_TALLY, 8'h02, "crc tally cable");
  endtask : cable_tests

  task miss_tests;
    for (int i = 0; i < 328; i++) begin
      miss <= 1'b1;
      @(posedge clk) miss <= 1'b0;
      @(posedge clk);
      if (i == 127) begin
        @(negedge clk) chk("tally irq", 8'h01, {7'h0, irq});
        @(posedge clk);
        rd_reg(ADDR_MISS_TALLY, 8'h80, "miss tally");
        @(negedge clk) chk("tally irq cleared", 8'h00, {7'h0, irq});
        @(posedge clk);
      end
    end
    rd_reg(ADDR_MISS_TALLY, 8'hC0, "miss tally saturated");
  endtask : miss_tests

  initial begin
    {nrst, wr, rd, am, mm, miss, rst_m, slow, car, col, ae, addr, wd} = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_reg(ADDR_INT_STATUS, 8'h00, "int status reset");
    crc_tests();
    align_tests();
    cable_tests();
    miss_tests();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule : tb_loop_tally
